/* bench/mwo_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host-side image of every byte that software has stored at one of the six mapped offsets
module mwo_host_model (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [12:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr
);
    logic [7:0] img [logic [12:0]]; // Stored bytes by full address
    // Follow writes; reset wipes the image
    always @(posedge clock)
        if (sys_rst)
            img.delete(); // Everything reads 00h
        else if (reg_wr && (reg_addr[11:0] inside {12'h815, 12'h81D, 12'h825, 12'h82D, 12'h834, 12'h835}))
            img[reg_addr] = reg_wdata; // Only the addressed byte
    // Expected read value, 00h where nothing is mapped
    function automatic logic [7:0] peek(input logic [12:0] a);
        return img.exists(a) ? img[a] : 8'h00;
    endfunction
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                    clock = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, acc_write = 0, acc_write_blocked;
    logic [12:0]             reg_addr = '0;
    logic [7:0]              reg_wdata = '0, reg_rdata, v;
    logic [1:0]              acc_socket = '0;
    logic [2:0]              acc_window = '0;
    mwo_pkg::mwo_win_s [9:0] win_cfg;
    logic [15:0]             win4_offset_lower;
    int                      num_errors = 0, tests_run = 0, cyc = 0;
    logic [11:0]             offs [6] = '{12'h815, 12'h81D, 12'h825, 12'h82D, 12'h835, 12'h834};
    // 40 MHz clock
    always #12.5 clock = ~clock;
    mwo_regs u_dut (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .acc_socket,
                    .acc_window, .acc_write, .acc_write_blocked, .win_cfg, .win4_offset_lower);
    mwo_host_model u_host (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr);
    // Compare and count
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    // Write strobe raised right after a rising edge and left high; a following wr keeps it, rd lowers it, so writes may run back to back
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
    endtask
    // Read strobe for one cycle; data sampled in the following cycle only
    task automatic rd(input logic [12:0] a);
        reg_rd   <= 1'b1;
        reg_wr   <= 1'b0;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        chk(reg_rdata, u_host.peek(a));
        @(posedge clock);
    endtask
    // Verdict and end of run
    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            num_errors++;
            report_and_stop();
        end
    end
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        for (int i = 0; i < 12; i++)
            rd(13'(i / 6 * 4096) + offs[i % 6]);
        $display("Reset values done");
        for (int i = 0; i < 10; i++)
            wr(13'(i / 5 * 4096) + offs[i % 5], 8'(i * 41 + 17));
        wr(13'h1834, 8'hA5);
        wr(13'h0816, 8'hFF);
        for (int i = 0; i < 12; i++)
            rd(13'(i / 6 * 4096) + offs[i % 6]);
        rd(13'h0816);
        $display("Readback done");
        for (int i = 0; i < 10; i++)
        begin
            v = 8'(i * 41 + 17);
            @(posedge clock);
            acc_socket <= 2'(i / 5);
            acc_window <= 3'(i % 5);
            acc_write <= 1'b1;
            @(negedge clock);
            chk({7'h00, acc_write_blocked}, {7'h00, v[7]});
            chk(win_cfg[i], v);
        end
        @(posedge clock);
        acc_socket <= 2'h2;
        acc_window <= 3'h4;
        @(negedge clock);
        chk({7'h00, acc_write_blocked}, 8'h00);
        @(posedge clock);
        acc_socket <= 2'h1;
        acc_write  <= 1'b0;
        @(negedge clock);
        chk({7'h00, acc_write_blocked}, 8'h00);
        chk(win4_offset_lower[15:8], 8'hA5);
        chk(win4_offset_lower[7:0], 8'h00);
        $display("Window outputs done");
        @(posedge clock);
        wr(13'h0815, 8'hC5);
        rd(13'h0815);
        chk(win_cfg[0], 8'hC5);
        $display("Back to back done");
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        for (int i = 0; i < 12; i++)
            rd(13'(i / 6 * 4096) + offs[i % 6]);
        for (int i = 0; i < 10; i++)
            chk(win_cfg[i], 8'h00);
        $display("Second reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire

/* verilog/mwo_pkg.sv */
`default_nettype none
package mwo_pkg;
    // Socket and window counts
    localparam int NUM_SOCKETS = 2;
    localparam int NUM_WINDOWS = 5;
    // Register address width within one socket space
    localparam int ADDR_W = 12;
    // Socket select sits above the per-socket space
    localparam int SOCK_BIT = 12;
    // Register offsets: high byte per window, plus the window 4 low byte
    localparam logic [11:0] WIN0_UPPER_OFS = 12'h815;
    localparam logic [11:0] WIN1_UPPER_OFS = 12'h81D;
    localparam logic [11:0] WIN2_UPPER_OFS = 12'h825;
    localparam logic [11:0] WIN3_UPPER_OFS = 12'h82D;
    localparam logic [11:0] WIN4_LOWER_OFS = 12'h834;
    localparam logic [11:0] WIN4_UPPER_OFS = 12'h835;
    // Reset values
    localparam logic [7:0] UPPER_RESET = 8'h00;
    localparam logic [7:0] LOWER_RESET = 8'h00;
    // Field positions
    localparam int WP_BIT = 7;
    localparam int ATTR_BIT = 6;
    localparam int OFS_MSB = 5;

    // Per-window attributes handed to translation and cycle logic
    typedef struct packed {
        logic       window_write_protect;
        logic       attr_select;
        logic [5:0] offset_upper_bits;
    } mwo_win_s;
endpackage
`default_nettype wire

/* verilog/mwo_regs.sv */
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mwo_regs (
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    input  wire logic [12:0]            reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    input  wire logic [1:0]             acc_socket,
    input  wire logic [2:0]             acc_window,
    input  wire logic                   acc_write,
    output logic                        acc_write_blocked,
    output mwo_pkg::mwo_win_s [9:0]     win_cfg,
    output logic [15:0]                 win4_offset_lower
);
    // Upper offset register array, indexed socket*5+window
    // Socket A owns entries 0 to 4, socket B entries 5 to 9
    logic [7:0] upper_q [10];
    // Window 4 low-byte register per socket
    logic [7:0] lower_q [2];
    // Decoded window of the current address, 7 means none
    logic [2:0] hit_win;
    // Address names the window 4 low byte
    logic       hit_lower;
    // Socket named by the top address bit
    logic       sock;
    // Read value before the output register
    logic [7:0] rdata_d;

    // Socket select; offsets repeat identically in both halves
    assign sock = reg_addr[mwo_pkg::SOCK_BIT];

    // Address decode within the socket space
    // Only the low twelve bits take part, so both sockets share one decoder
    // Any offset outside the six mapped bytes falls to the default branch
    always_comb
    begin
        hit_win   = 3'h7;
        hit_lower = 1'b0;
        case (reg_addr[11:0])
            mwo_pkg::WIN0_UPPER_OFS: hit_win = 3'h0;
            mwo_pkg::WIN1_UPPER_OFS: hit_win = 3'h1;
            mwo_pkg::WIN2_UPPER_OFS: hit_win = 3'h2;
            mwo_pkg::WIN3_UPPER_OFS: hit_win = 3'h3;
            mwo_pkg::WIN4_UPPER_OFS: hit_win = 3'h4;
            mwo_pkg::WIN4_LOWER_OFS: hit_lower = 1'b1;
            default:                 hit_win = 3'h7;
        endcase
    end

    // One storage flop group per socket and window
    // Each entry has its own process, so a write can never spill into a neighbour
    // Reset wins over a write that falls in the same cycle
    // Only the window 4 low byte is kept; the other low bytes live elsewhere
    genvar gs, gw;
    generate
        for (gs = 0; gs < mwo_pkg::NUM_SOCKETS; gs++)
        begin : g_sock
            for (gw = 0; gw < mwo_pkg::NUM_WINDOWS; gw++)
            begin : g_win
                always_ff @(posedge clock)
                begin
                    if (sys_rst)
                        upper_q[gs*5+gw] <= mwo_pkg::UPPER_RESET;
                    else if (reg_wr && hit_win == 3'(gw) && sock == 1'(gs))
                        upper_q[gs*5+gw] <= reg_wdata;
                end
                // Field split for downstream logic
                assign win_cfg[gs*5+gw].window_write_protect =
                    upper_q[gs*5+gw][mwo_pkg::WP_BIT];
                assign win_cfg[gs*5+gw].attr_select =
                    upper_q[gs*5+gw][mwo_pkg::ATTR_BIT];
                assign win_cfg[gs*5+gw].offset_upper_bits =
                    upper_q[gs*5+gw][mwo_pkg::OFS_MSB:0];
            end
            // Window 4 low byte
            // Same write path as the high bytes, with its own decode hit
            always_ff @(posedge clock)
            begin
                if (sys_rst)
                    lower_q[gs] <= mwo_pkg::LOWER_RESET;
                else if (reg_wr && hit_lower && sock == 1'(gs))
                    lower_q[gs] <= reg_wdata;
            end
            assign win4_offset_lower[gs*8 +: 8] = lower_q[gs];
        end
    endgenerate

    // Read mux, unmapped addresses read zero
    // The index is formed only on a valid hit, so it stays within 0 to 9
    // Socket B entries sit five above their socket A twins
    always_comb
    begin
        rdata_d = 8'h00;
        if (hit_win != 3'h7)
            rdata_d = upper_q[(sock ? 5 : 0) + 32'(hit_win)];
        else if (hit_lower)
            rdata_d = lower_q[sock];
    end

    // Read data registered, valid the cycle after the strobe
    // Returning to zero between reads keeps a stale byte off the bus
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rdata_d;
        else
            reg_rdata <= 8'h00;
    end

    // Write-cycle gate for the card access generator
    // Requests naming a socket or window that does not exist are never blocked
    // Kept combinational so the cycle generator sees the gate in the same cycle
    always_comb
    begin
        acc_write_blocked = 1'b0;
        if (acc_write && acc_socket < 2'h2 && acc_window < 3'h5)
            acc_write_blocked =
                upper_q[(acc_socket[0] ? 5 : 0) + 32'(acc_window)][mwo_pkg::WP_BIT];
    end

    // Checks on what this block drives, all sampled on the rising clock
    // Reset is the only disable; it is synchronous and level sensitive

    // Reset clears every window byte and the read port
    reset_clear_a: assert property (@(posedge clock)
        sys_rst
        |=> (win_cfg == '0 && win4_offset_lower == 16'h0000 && reg_rdata == 8'h00))
        else $error("registers not cleared by reset");

    // Write then read of window 0 returns the written byte
    write_read_a: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_wr && reg_addr == {1'b0, mwo_pkg::WIN0_UPPER_OFS})
        ##1 (reg_rd && reg_addr == {1'b0, mwo_pkg::WIN0_UPPER_OFS})
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("window register readback mismatch");

    // Socket B untouched by a socket A write
    socket_isolation_a: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_wr && !reg_addr[mwo_pkg::SOCK_BIT])
        |=> ($stable(win_cfg[9:5]) && $stable(win4_offset_lower[15:8])))
        else $error("other socket changed");

    // Socket A untouched by a socket B write
    socket_b_isolation_a: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_wr && reg_addr[mwo_pkg::SOCK_BIT])
        |=> ($stable(win_cfg[4:0]) && $stable(win4_offset_lower[7:0])))
        else $error("socket A changed by a socket B write");

    // Unmapped writes leave every setting alone
    unmapped_write_a: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_wr && hit_win == 3'h7 && !hit_lower)
        |=> ($stable(win_cfg) && $stable(win4_offset_lower)))
        else $error("unmapped write changed a setting");

    // Socket A window 3 gate follows its protect bit
    protect_block_a: assert property (@(posedge clock) disable iff (sys_rst)
        (acc_write && acc_socket == 2'h0 && acc_window == 3'h3)
        |-> acc_write_blocked == win_cfg[3].window_write_protect)
        else $error("window 3 gate differs from protect bit");

    // Socket B window 4 gate follows its protect bit
    protect_sock_b_a: assert property (@(posedge clock) disable iff (sys_rst)
        (acc_write && acc_socket == 2'h1 && acc_window == 3'h4)
        |-> acc_write_blocked == win_cfg[9].window_write_protect)
        else $error("socket B window 4 gate differs from protect bit");

    // No gate without a write request
    write_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
        !acc_write
        |-> !acc_write_blocked)
        else $error("gate raised without a write request");

    // A socket or window that does not exist is never gated
    bad_target_a: assert property (@(posedge clock) disable iff (sys_rst)
        (acc_socket > 2'h1 || acc_window > 3'h4)
        |-> !acc_write_blocked)
        else $error("gate raised for a missing window");

    // Protect bit follows written bit 7
    protect_field_a: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_wr && reg_addr == {1'b0, mwo_pkg::WIN2_UPPER_OFS})
        |=> win_cfg[2].window_write_protect == $past(reg_wdata[mwo_pkg::WP_BIT]))
        else $error("protect bit not loaded");

    // Offset field follows written low bits
    offset_field_a: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_wr && reg_addr == {1'b1, mwo_pkg::WIN4_UPPER_OFS})
        |=> win_cfg[9].offset_upper_bits == $past(reg_wdata[mwo_pkg::OFS_MSB:0]))
        else $error("offset bits not loaded");

    // Attribute select follows bit 6
    attr_field_a: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_wr && reg_addr == {1'b0, mwo_pkg::WIN1_UPPER_OFS})
        |=> win_cfg[1].attr_select == $past(reg_wdata[mwo_pkg::ATTR_BIT]))
        else $error("attribute select not loaded");

    // Window 4 low byte of socket B follows its write
    lower_load_a: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_wr && reg_addr == {1'b1, mwo_pkg::WIN4_LOWER_OFS})
        |=> win4_offset_lower[15:8] == $past(reg_wdata))
        else $error("window 4 low byte not loaded");

    // Read data returns to zero when no read was taken
    rdata_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
        !reg_rd
        |=> reg_rdata == 8'h00)
        else $error("read data not idle after a quiet cycle");

    // Unmapped reads return zero
    unmapped_read_a: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_rd && hit_win == 3'h7 && !hit_lower)
        |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");
endmodule
`default_nettype wire
